// ==== core/recovery_counter.sv ====
// Purpose: 12 counting stages plus a 13th stage that gives the watchdog tick
// Assumes: controls come from rising-edge flops, half a cycle of setup
// Notes:   falling-edge clocked; reset arrives only through clear_all, a rising-edge flop,
//          so a reset that moves on a falling edge never races these stages
`timescale 1ns/100ps
`default_nettype none
module recovery_counter
    import reset_seq_pkg::*;
(
    input  wire logic i_clock,
    recovery_if.ctr   rc
);
    logic [RC_WIDTH-1:0] count_q;
    logic                stage13_q;

    // ****************************************************************
    // counting stages
    // ****************************************************************
    always_ff @(negedge i_clock) begin // RQ18
        if (rc.clear_all) begin // RQ19 RQ22
            count_q <= '0;
        end else if (rc.clear_upper) begin // RQ10
            count_q <= {8'h00, count_q[UPPER_CLR_LO-1:0]} + 12'h001;
        end else begin
            count_q <= count_q + 12'h001; // RQ21
        end
    end

    // 13th stage: marks each wrap of the 12 stages
    always_ff @(negedge i_clock) begin // RQ17
        if (rc.clear_all) begin
            stage13_q <= 1'b0;
        end else begin
            stage13_q <= (count_q == 12'hFFF) && !rc.clear_upper; // RQ11
        end
    end

    assign rc.count = count_q;
    assign rc.tick  = stage13_q;
endmodule // recovery_counter
`default_nettype wire

// ==== core/recovery_if.sv ====
// Purpose: carries control and count between sequencer and recovery counter
// Assumes: one clock domain
// Notes:   counter side updates on the falling edge
`timescale 1ns/100ps
`default_nettype none
interface recovery_if;
    import reset_seq_pkg::*;
    logic                clear_all;
    logic                clear_upper;
    logic [RC_WIDTH-1:0] count;
    logic                tick;
    modport ctrl (output clear_all, output clear_upper, input count, input tick);
    modport ctr  (input clear_all, input clear_upper, output count, output tick);
endinterface
`default_nettype wire

// ==== core/reset_seq_pkg.sv ====
// Purpose: shared constants and types of the reset sequencer
// Assumes: i_clock is the fast base clock at CLOCK_MHZ
// Notes:   cause bit positions are fixed for software readback
// ****************************************************************
// constants
// ****************************************************************
package reset_seq_pkg;
    localparam int CLOCK_MHZ       = 100;
    localparam int T_RL_MIN_NS     = 100;
    localparam int T_RL_CYCLES     = (T_RL_MIN_NS * CLOCK_MHZ + 999) / 1000;
    localparam int RC_WIDTH        = 12;
    localparam int DRIVE_CYCLES    = 32;
    localparam int HOLD_CYCLES     = 32;
    localparam int SETTLE_CYCLES   = 3;
    localparam int SHORT_STOP_CYC  = 32;
    localparam int SEQ_WIDTH       = 6;
    localparam int PIN_CNT_WIDTH   = 8;
    localparam int BUS_DIV_WIDTH   = 2;
    localparam int UPPER_CLR_LO    = 4;
    localparam int UPPER_CLR_HI    = 11;

    localparam int CAUSE_WIDTH     = 6;
    localparam int CAUSE_POWER_ON  = 0;
    localparam int CAUSE_PIN       = 1;
    localparam int CAUSE_WATCHDOG  = 2;
    localparam int CAUSE_BAD_OP    = 3;
    localparam int CAUSE_BAD_ADDR  = 4;
    localparam int CAUSE_LOW_VOLT  = 5;
    localparam logic [CAUSE_WIDTH-1:0] CAUSE_RESET = 6'h01;

    typedef enum logic [3:0] {
        ST_RUN       = 4'b0000,
        ST_POR_WAIT  = 4'b0001,
        ST_LVD_LOW   = 4'b0010,
        ST_DRIVE     = 4'b0011,
        ST_HOLD      = 4'b0100,
        ST_SETTLE    = 4'b0101,
        ST_PIN_LOW   = 4'b0110,
        ST_STOP      = 4'b0111,
        ST_STOP_WAKE = 4'b1000
    } seq_state_e;
endpackage

// ==== core/reset_sequencer.sv ====
// Purpose: gathers reset sources, drives the reset pin, sequences internal reset
// Assumes: i_clock is the fast base clock; reset pin arrives asynchronously
// Notes:   pin is a GPIO input until the function enable is set
// Overview of operation
// RQ1: low pin halts processing while held
// RQ2: pin flag only after minimum low time
// RQ3: pin is GPIO until function enabled
// RQ4: internal resets drive pin low 32 cycles
// RQ5: internal reset holds 32 more cycles
// RQ6: recovery 4163 for POR/LOW_VOLTAGE_DETECT, else 67
// RQ7: POR counts 4096 then releases later
// RQ8: POR asserts reset, osc on, clocks off
// RQ9: watchdog overflow resets, sets its flag
// RQ10: service write clears watchdog, upper stages
// RQ11: watchdog tick at least every 4096
// RQ12: watchdog suspended in monitor break
// RQ13: illegal opcode sets flag and resets
// RQ14: stop disabled makes stop illegal
// RQ15: only unmapped opcode fetch resets
// RQ16: low voltage holds pin during count
// RQ17: 12 stages plus 13th tick stage
// RQ18: counter advances on falling edge
// RQ19: stop instruction clears counter
// RQ20: stop wake waits 32 or 4096
// RQ21: pin reset leaves counter running
// RQ22: internal reset clears counter
// RQ23: bus clock is base divided by four
// RQ24: cause flags readable after reset
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer
    import reset_seq_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_reset,
    input  wire logic                   i_reset_pin_in,
    output logic                        o_reset_pin_out,
    output logic                        o_reset_pin_oe,
    output logic                        o_gpio_in,
    input  wire logic                   i_reset_pin_function_enable,
    input  wire logic                   i_short_stop_recovery,
    input  wire logic                   i_stop_enable_option,
    input  wire logic                   i_power_on_pulse,
    input  wire logic                   i_low_voltage_detect,
    input  wire logic                   i_watchdog_overflow,
    input  wire logic                   i_watchdog_service_write,
    input  wire logic                   i_break_active,
    input  wire logic                   i_monitor_mode,
    input  wire logic                   i_break_watchdog_disable,
    input  wire logic                   i_opcode_illegal,
    input  wire logic                   i_stop_exec,
    input  wire logic                   i_unmapped_access,
    input  wire logic                   i_opcode_fetch,
    input  wire logic                   i_wake_event,
    output logic                        o_internal_reset,
    output logic                        o_clocks_enable,
    output logic                        o_osc_enable,
    output logic                        o_bus_clock,
    output logic                        o_watchdog_tick,
    output logic                        o_watchdog_clear,
    output logic                        o_watchdog_suspend,
    output logic [CAUSE_WIDTH-1:0]      o_reset_cause
);
    localparam int LVD_MAX = 300;

    recovery_if rc ();

    recovery_counter u_recovery_counter (
        .i_clock (i_clock),
        .rc      (rc.ctr)
    );

    seq_state_e                 state_q;
    seq_state_e                 state_d;
    logic [SEQ_WIDTH-1:0]       seq_q;
    logic [PIN_CNT_WIDTH-1:0]   pin_cnt_q;
    logic                       pin_meta_q;
    logic                       pin_sync_q;
    logic                       lvd_path_q;
    logic                       clear_all_q;
    logic                       clear_upper_q;
    logic [BUS_DIV_WIDTH-1:0]   bus_div_q;
    logic [CAUSE_WIDTH-1:0]     cause_q;
    logic                       pin_low;
    logic                       bad_op;
    logic                       bad_fetch;
    logic                       internal_event;
    logic                       suspend;

    function automatic logic in_reset(input seq_state_e s);
        in_reset = (s != ST_RUN) && (s != ST_STOP) && (s != ST_STOP_WAKE);
    endfunction

    // ****************************************************************
    // pin synchroniser and qualification
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
        end else begin
            pin_meta_q <= i_reset_pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    always_ff @(posedge i_clock) begin // RQ3
        if (i_reset) begin
            o_gpio_in <= 1'b1;
        end else begin
            o_gpio_in <= pin_sync_q;
        end
    end

    assign pin_low        = i_reset_pin_function_enable && !pin_sync_q; // RQ3
    assign bad_op         = i_opcode_illegal || (i_stop_exec && !i_stop_enable_option); // RQ13 RQ14
    assign bad_fetch      = i_unmapped_access && i_opcode_fetch; // RQ15
    assign internal_event = i_watchdog_overflow || bad_op || bad_fetch;
    assign suspend        = i_break_active && i_monitor_mode && i_break_watchdog_disable; // RQ12

    // ****************************************************************
    // sequence state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        if (i_power_on_pulse) begin
            state_d = ST_POR_WAIT; // RQ8
        end else if (i_low_voltage_detect) begin
            state_d = ST_LVD_LOW; // RQ16
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (internal_event) begin
                        state_d = ST_DRIVE; // RQ9 RQ13 RQ15
                    end else if (pin_low) begin
                        state_d = ST_PIN_LOW; // RQ1
                    end else if (i_stop_exec) begin
                        state_d = ST_STOP;
                    end
                end
                ST_POR_WAIT: begin
                    if (rc.tick) begin
                        state_d = ST_DRIVE; // RQ7
                    end
                end
                ST_LVD_LOW: begin
                    state_d = ST_POR_WAIT;
                end
                ST_DRIVE: begin
                    if (seq_q == SEQ_WIDTH'(DRIVE_CYCLES - 1)) begin
                        state_d = ST_HOLD; // RQ4
                    end
                end
                ST_HOLD: begin
                    if (seq_q == SEQ_WIDTH'(HOLD_CYCLES - 1)) begin
                        state_d = ST_SETTLE; // RQ5
                    end
                end
                ST_SETTLE: begin
                    if (seq_q == SEQ_WIDTH'(SETTLE_CYCLES - 1)) begin
                        state_d = ST_RUN; // RQ6
                    end
                end
                ST_PIN_LOW: begin
                    if (!pin_low) begin
                        state_d = ST_HOLD; // RQ21
                    end
                end
                ST_STOP: begin
                    if (pin_low) begin
                        state_d = ST_PIN_LOW;
                    end else if (i_wake_event) begin
                        state_d = ST_STOP_WAKE;
                    end
                end
                ST_STOP_WAKE: begin
                    if (pin_low) begin
                        state_d = ST_PIN_LOW;
                    end else if (i_short_stop_recovery ?
                                 (rc.count == RC_WIDTH'(SHORT_STOP_CYC)) : rc.tick) begin
                        state_d = ST_RUN; // RQ20
                    end
                end
                default: begin
                    state_d = ST_POR_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q <= ST_POR_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // phase counter restarts on every state change
    always_ff @(posedge i_clock) begin
        if (i_reset || state_d != state_q) begin
            seq_q <= '0;
        end else begin
            seq_q <= seq_q + 6'h01;
        end
    end

    // lvd recovery keeps the pin low through the long count
    always_ff @(posedge i_clock) begin
        if (i_reset || i_power_on_pulse) begin
            lvd_path_q <= 1'b0;
        end else if (state_d == ST_LVD_LOW) begin
            lvd_path_q <= 1'b1;
        end else if (state_d == ST_RUN) begin
            lvd_path_q <= 1'b0;
        end
    end

    // ****************************************************************
    // recovery counter control
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            clear_all_q <= 1'b1;
        end else begin
            // leaving low voltage the counter is already clear; clearing again would add a cycle
            clear_all_q <= (state_d == ST_LVD_LOW) || (state_d == ST_STOP) // RQ19
                           || (state_d != state_q && state_d == ST_DRIVE) // RQ22
                           || (state_d != state_q && state_d == ST_POR_WAIT && state_q != ST_LVD_LOW); // RQ22
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            clear_upper_q <= 1'b0;
        end else begin
            clear_upper_q <= i_watchdog_service_write; // RQ10
        end
    end

    assign rc.clear_all   = clear_all_q;
    assign rc.clear_upper = clear_upper_q;

    // ****************************************************************
    // pin low time and cause flags
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_reset || state_q != ST_PIN_LOW) begin
            pin_cnt_q <= '0;
        end else if (pin_cnt_q != PIN_CNT_WIDTH'(T_RL_CYCLES)) begin
            pin_cnt_q <= pin_cnt_q + 8'h01; // RQ2
        end
    end

    // the newest source replaces older ones so software sees the last cause
    always_ff @(posedge i_clock) begin // RQ24
        if (i_reset || i_power_on_pulse) begin
            cause_q <= CAUSE_RESET; // RQ8
        end else if (i_low_voltage_detect) begin
            cause_q <= CAUSE_WIDTH'(1) << CAUSE_LOW_VOLT; // RQ16
        end else if (state_q == ST_RUN && i_watchdog_overflow) begin
            cause_q <= CAUSE_WIDTH'(1) << CAUSE_WATCHDOG; // RQ9
        end else if (state_q == ST_RUN && bad_op) begin
            cause_q <= CAUSE_WIDTH'(1) << CAUSE_BAD_OP; // RQ13
        end else if (state_q == ST_RUN && bad_fetch) begin
            cause_q <= CAUSE_WIDTH'(1) << CAUSE_BAD_ADDR; // RQ15
        end else if (state_q == ST_PIN_LOW && pin_cnt_q == PIN_CNT_WIDTH'(T_RL_CYCLES - 1)) begin
            cause_q <= CAUSE_WIDTH'(1) << CAUSE_PIN; // RQ2
        end
    end
    assign o_reset_cause = cause_q;

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_internal_reset <= 1'b1;
            o_clocks_enable  <= 1'b0;
            o_osc_enable     <= 1'b1;
        end else begin
            o_internal_reset <= in_reset(state_d); // RQ1 RQ5
            o_clocks_enable  <= !in_reset(state_d) && state_d != ST_STOP && state_d != ST_STOP_WAKE; // RQ8
            o_osc_enable     <= state_d != ST_STOP; // RQ8
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reset_pin_out <= 1'b0;
            o_reset_pin_oe  <= 1'b0;
        end else begin
            o_reset_pin_out <= 1'b0;
            o_reset_pin_oe  <= i_reset_pin_function_enable &&
                               ((state_d == ST_DRIVE) || // RQ4
                                (lvd_path_q && state_d == ST_POR_WAIT) || state_d == ST_LVD_LOW); // RQ16
        end
    end

    always_ff @(posedge i_clock) begin // RQ23
        if (i_reset) begin
            bus_div_q   <= '0;
            o_bus_clock <= 1'b0;
        end else begin
            bus_div_q   <= bus_div_q + 2'h1;
            o_bus_clock <= bus_div_q[1];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_watchdog_tick    <= 1'b0;
            o_watchdog_clear   <= 1'b0;
            o_watchdog_suspend <= 1'b0;
        end else begin
            o_watchdog_tick    <= rc.tick && !suspend; // RQ11 RQ12
            o_watchdog_clear   <= i_watchdog_service_write; // RQ10
            o_watchdog_suspend <= suspend; // RQ12
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_pin_halt;
        @(posedge i_clock) disable iff (i_reset)
        (state_q == ST_RUN && pin_low && !internal_event && !i_power_on_pulse && !i_low_voltage_detect)
        |=> o_internal_reset && state_q == ST_PIN_LOW;
    endproperty
    a_pin_halt: assert property (p_pin_halt) else $error("pin low did not halt"); // RQ1

    property p_drive_len;
        @(posedge i_clock) disable iff (i_reset || i_power_on_pulse || i_low_voltage_detect)
        (state_q == ST_DRIVE && seq_q == 6'h1F) |=> state_q == ST_HOLD;
    endproperty
    a_drive_len: assert property (p_drive_len) else $error("drive phase length wrong"); // RQ4

    property p_hold_no_drive;
        @(posedge i_clock) disable iff (i_reset)
        (state_q == ST_HOLD) |-> !o_reset_pin_oe && o_internal_reset;
    endproperty
    a_hold_no_drive: assert property (p_hold_no_drive) else $error("hold phase drives pin"); // RQ5

    property p_settle_release;
        @(posedge i_clock) disable iff (i_reset || i_power_on_pulse || i_low_voltage_detect)
        (state_q == ST_SETTLE && seq_q == 6'h02) |=> !o_internal_reset && state_q == ST_RUN;
    endproperty
    a_settle_release: assert property (p_settle_release) else $error("release not after settle"); // RQ6

    property p_por_entry;
        @(posedge i_clock) disable iff (i_reset)
        i_power_on_pulse |=> o_internal_reset && !o_clocks_enable && o_osc_enable
                             && o_reset_cause == CAUSE_RESET;
    endproperty
    a_por_entry: assert property (p_por_entry) else $error("power-on entry wrong"); // RQ8

    property p_watchdog_reset;
        @(posedge i_clock) disable iff (i_reset)
        (state_q == ST_RUN && i_watchdog_overflow && !i_power_on_pulse && !i_low_voltage_detect)
        |=> o_reset_cause[CAUSE_WATCHDOG] && o_internal_reset;
    endproperty
    a_watchdog_reset: assert property (p_watchdog_reset) else $error("watchdog reset missing"); // RQ9

    property p_data_access_safe;
        @(posedge i_clock) disable iff (i_reset)
        (state_q == ST_RUN && i_unmapped_access && !i_opcode_fetch && !i_watchdog_overflow && !bad_op
         && !pin_low && !i_stop_exec && !i_power_on_pulse && !i_low_voltage_detect)
        |=> state_q == ST_RUN;
    endproperty
    a_data_access_safe: assert property (p_data_access_safe) else $error("data access caused reset"); // RQ15

    property p_stop_illegal;
        @(posedge i_clock) disable iff (i_reset)
        (state_q == ST_RUN && i_stop_exec && !i_stop_enable_option && !i_power_on_pulse
         && !i_low_voltage_detect && !i_watchdog_overflow)
        |=> o_reset_cause[CAUSE_BAD_OP] && state_q == ST_DRIVE;
    endproperty
    a_stop_illegal: assert property (p_stop_illegal) else $error("disabled stop not illegal"); // RQ14

    property p_bus_div;
        @(posedge i_clock) disable iff (i_reset)
        $rose(o_bus_clock) |=> o_bus_clock ##1 !o_bus_clock ##1 !o_bus_clock ##1 o_bus_clock;
    endproperty
    a_bus_div: assert property (p_bus_div) else $error("bus clock not divide by four"); // RQ23

    property p_service;
        @(posedge i_clock) disable iff (i_reset)
        // after the clear only the low stages plus one carry can be set
        i_watchdog_service_write |=> o_watchdog_clear && rc.count <= 12'h010;
    endproperty
    a_service: assert property (p_service) else $error("service write did not clear"); // RQ10

    property p_suspend;
        @(posedge i_clock) disable iff (i_reset)
        suspend |=> o_watchdog_suspend && !o_watchdog_tick;
    endproperty
    a_suspend: assert property (p_suspend) else $error("watchdog not suspended"); // RQ12

    property p_lvd_pin;
        @(posedge i_clock) disable iff (i_reset || i_power_on_pulse || i_low_voltage_detect)
        (lvd_path_q && state_q == ST_POR_WAIT && i_reset_pin_function_enable && !rc.tick)
        |=> o_reset_pin_oe;
    endproperty
    a_lvd_pin: assert property (p_lvd_pin) else $error("pin released during lvd count"); // RQ16

endmodule // reset_sequencer
`default_nettype wire

// ==== dv/board_reset_line.sv ====
// Purpose: board side of the reset pin, pull-up plus outside pull-down
// Assumes: device drives the pin only while its enable is high
// Notes:   a released pin reads high through the pull-up, never the last value
`timescale 1ns/100ps
`default_nettype none
module board_reset_line (
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    input  wire logic i_hold_low,
    output logic      o_level
);
    // either party may pull down, nobody drives high
    assign o_level = ((i_pin_oe && !i_pin_out) || i_hold_low) ? 1'h0 : 1'h1;
endmodule // board_reset_line
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench of the reset sequencer
// Assumes: 100 MHz clock, inputs move on falling edges
// Notes:   reset tails are measured in falling-edge samples
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import reset_seq_pkg::*;
    logic                   i_clock = 0;
    logic                   i_reset = 1;
    logic                   hold_low = 0;
    logic [14:0]            ctl = '0;
    logic                   pin, oe, po, gpio, internal_reset, clk_en, osc, bclk, tick, wclr, susp;
    logic [CAUSE_WIDTH-1:0] cause;
    int                     failures = 0, check_count = 0, nr, no, n;
    int                     src[4] = '{5, 10, 11, 12};
    logic [5:0]             exp_c[4] = '{6'h04, 6'h08, 6'h08, 6'h10};

    always #5 i_clock = ~i_clock;

    board_reset_line i_board_reset_line (.i_pin_out(po), .i_pin_oe(oe), .i_hold_low(hold_low), .o_level(pin));
    reset_sequencer i_reset_sequencer (
        .i_clock(i_clock), .i_reset(i_reset), .i_reset_pin_in(pin), .o_reset_pin_out(po),
        .o_reset_pin_oe(oe), .o_gpio_in(gpio), .i_reset_pin_function_enable(ctl[0]),
        .i_short_stop_recovery(ctl[1]), .i_stop_enable_option(ctl[2]), .i_power_on_pulse(ctl[3]),
        .i_low_voltage_detect(ctl[4]), .i_watchdog_overflow(ctl[5]), .i_watchdog_service_write(ctl[6]),
        .i_break_active(ctl[7]), .i_monitor_mode(ctl[8]), .i_break_watchdog_disable(ctl[9]),
        .i_opcode_illegal(ctl[10]), .i_stop_exec(ctl[11]), .i_unmapped_access(ctl[12]),
        .i_opcode_fetch(ctl[13]), .i_wake_event(ctl[14]), .o_internal_reset(internal_reset),
        .o_clocks_enable(clk_en), .o_osc_enable(osc), .o_bus_clock(bclk), .o_watchdog_tick(tick),
        .o_watchdog_clear(wclr), .o_watchdog_suspend(susp), .o_reset_cause(cause));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic pulse(input int b);
        @(negedge i_clock) ctl[b] = 1;
        @(negedge i_clock) ctl[b] = 0;
    endtask

    // counts reset and pin-drive samples until internal reset has ended
    task automatic measure(input int lim);
        nr = 0;
        no = 0;
        repeat (lim) begin
            @(negedge i_clock);
            ctl[12:3] = '0;
            nr += (internal_reset === 1'h1);
            no += (oe === 1'h1);
            if (internal_reset === 1'h0 && nr > 0) return;
        end
        failures++;
        summarize();
    endtask

    task automatic wait_n(input int k);
        repeat (k) @(negedge i_clock);
    endtask

    initial begin
        wait_n(8);
        i_reset = 0;
        check(cause, 6'h01);
        measure(6000);
        check(nr >= 4163 && nr <= 4170, 1);
        check(no, 0);
        ctl[0] = 1;
        ctl[13] = 1;
        for (int k = 0; k < 4; k++) begin
            @(negedge i_clock) ctl[src[k]] = 1;
            measure(200);
            check(nr, 67);
            check(no, DRIVE_CYCLES);
            check(cause, exp_c[k]);
        end
        @(negedge i_clock) ctl[13] = 0;
        pulse(12);
        wait_n(10);
        check(internal_reset, 0);
        // a pulse shorter than the minimum must halt but leave the cause alone
        hold_low = 1;
        wait_n(4);
        hold_low = 0;
        measure(100);
        check(cause, 6'h10);
        hold_low = 1;
        wait_n(T_RL_CYCLES + 10);
        check(internal_reset, 1);
        hold_low = 0;
        measure(100);
        check(no, 0);
        check(cause, 6'h02);
        @(negedge i_clock) ctl[6] = 1;
        n = 0;
        repeat (3) begin
            @(negedge i_clock);
            ctl[6] = 0;
            n += (wclr === 1'h1);
        end
        check(n, 1);
        ctl[9:7] = 3'h7;
        wait_n(2);
        check(susp, 1);
        ctl[9] = 0;
        wait_n(2);
        check(susp, 0);
        n = 0;
        repeat (8) begin
            @(negedge i_clock);
            n += (bclk === 1'h1);
        end
        check(n, 4);
        n = 0;
        repeat (4100) begin
            @(negedge i_clock);
            n += (tick === 1'h1);
        end
        check(n >= 1, 1);
        // with the function off the pin is only a plain input
        ctl[0] = 0;
        hold_low = 1;
        wait_n(4);
        check(gpio, 0);
        check(internal_reset, 0);
        hold_low = 0;
        // let the released level pass the synchroniser before the function is enabled
        wait_n(3);
        ctl[2:0] = 3'h7;
        pulse(11);
        wait_n(3);
        check({clk_en, osc}, 0);
        @(negedge i_clock) ctl[14] = 1;
        n = 0;
        repeat (60) begin
            @(negedge i_clock);
            ctl[14] = 0;
            n += (clk_en === 1'h0);
        end
        check(n >= 32 && n <= 40, 1);
        ctl[4] = 1;
        wait_n(20);
        ctl[4] = 0;
        measure(6000);
        check(cause, 6'h20);
        check(nr >= 4163 && nr <= 4170, 1);
        check(no >= 4096, 1);
        // a power-on pulse in mid-run restarts the long recovery
        @(negedge i_clock) ctl[3] = 1;
        measure(6000);
        check(cause, 6'h01);
        check(nr >= 4163 && nr <= 4170, 1);
        check(no, DRIVE_CYCLES);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
